/* fsps_regs.vh */
`ifndef FSPS_REGS_VH
`define FSPS_REGS_VH
// ----------------------------------------------------------------
// Register map (word addresses, one per register)
// ----------------------------------------------------------------
`define FSPS_ADDR_CTRL      4'h0
`define FSPS_ADDR_PTR       4'h1
`define FSPS_ADDR_DATA      4'h2
`define FSPS_ADDR_STATUS    4'h3
`define FSPS_ADDR_STORE     4'h4
`define FSPS_ADDR_LOAD      4'h5
// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define FSPS_BIT_ENABLE     0
`define FSPS_BIT_ERASE      1
`define FSPS_BIT_WRITE      2
`define FSPS_BIT_LOCKRD     3
`define FSPS_BIT_RSE        4
`define FSPS_BIT_BUSY       6
// ----------------------------------------------------------------
// Command codes (low five control bits)
// ----------------------------------------------------------------
`define FSPS_CMD_ERASE      5'h03
`define FSPS_CMD_LOAD       5'h01
`define FSPS_CMD_WRITE      5'h05
`define FSPS_CMD_LOCKRD     5'h09
`define FSPS_CMD_RSE        5'h11
// ----------------------------------------------------------------
// Pointer selects for lock and fuse read
// ----------------------------------------------------------------
`define FSPS_SEL_FUSE_LO    16'h0000
`define FSPS_SEL_LOCK       16'h0001
`define FSPS_SEL_FUSE_EXT   16'h0002
`define FSPS_SEL_FUSE_HI    16'h0003
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSPS_STORE_WIN      3'h4
`define FSPS_LOAD_WIN       3'h3
`define FSPS_PROG_TIME_NS   3700000
`define FSPS_CLK_NS         10
`define FSPS_PROG_CYC       ((`FSPS_PROG_TIME_NS + `FSPS_CLK_NS - 1) / `FSPS_CLK_NS)
`define FSPS_RST_CTRL       8'h00
`endif

/* fsps_page_buf.v */
`include "fsps_regs.vh"
// Temporary page buffer, flip-flop storage, random word order
module fsps_page_buf #(
   parameter WORDS = 32,
   parameter AW    = 5
) (
   // Clock and reset
   input  wire          ref_clk_i,
   input  wire          rst_n_i,
   // Write side
   input  wire          clear_i,
   input  wire          wr_i,
   input  wire [AW-1:0] wr_idx_i,
   input  wire [15:0]   wr_data_i,
   // Read side
   input  wire [AW-1:0] rd_idx_i,
   output wire [15:0]   rd_data_o,
   output wire          any_loaded_o
);
   reg [15:0]      mem_q [0:WORDS-1];
   reg [WORDS-1:0] vld_q;
   integer         k;

   // --------------------------------------------------------------
   // Storage; erased words read as all ones like blank flash
   // --------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vld_q <= {WORDS{1'b0}};
         for (k = 0; k < WORDS; k = k + 1) begin
            mem_q[k] <= 16'hFFFF;
         end
      end else if (clear_i) begin
         vld_q <= {WORDS{1'b0}};
         for (k = 0; k < WORDS; k = k + 1) begin
            mem_q[k] <= 16'hFFFF;
         end
      end else if (wr_i) begin
         mem_q[wr_idx_i] <= wr_data_i;
         vld_q[wr_idx_i] <= 1'b1;
      end
   end

   assign rd_data_o    = mem_q[rd_idx_i];
   assign any_loaded_o = |vld_q;
endmodule

/* fsps_seq.v */
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`include "fsps_regs.vh"
module fsps_seq #(
   parameter WORD_BITS = 5,
   parameter PAGE_BITS = 7,
   parameter PROG_CYC  = `FSPS_PROG_CYC
) (
   // Clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_n_i,
   // Avalon-MM slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // EEPROM write status (pin domain)
   input  wire        ee_busy_i,
   // Fuse and lock values, one means unprogrammed
   input  wire [7:0]  lock_bits_i,
   input  wire [7:0]  fuse_lo_i,
   input  wire [7:0]  fuse_hi_i,
   input  wire [7:0]  fuse_ext_i,
   // Program memory array port
   output reg         fl_erase_o,
   output reg         fl_prog_o,
   output reg  [PAGE_BITS-1:0] fl_page_o,
   output wire [WORD_BITS-1:0] fl_word_o,
   output wire [15:0] fl_wdata_o,
   output wire [PAGE_BITS+WORD_BITS-1:0] fl_raddr_o,
   input  wire [15:0] fl_rdata_i,
   // CPU halt
   output wire        cpu_halt_o
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_ERASE = 2'h1;
   localparam ST_WRITE = 2'h2;
   localparam CW = 23;

   reg [1:0]  st_q;
   reg [7:0]  ctrl_q;
   reg [15:0] ptr_q;
   reg [15:0] data_q;
   reg [2:0]  win_q;
   reg [CW-1:0] cnt_q;
   reg [PAGE_BITS-1:0] page_q;
   reg        ee_s1_q;
   reg        ee_s2_q;
   reg        ee_d_q;
   reg        pending_q;
   // Power-up value only; never touched by reset so a write survives it
   reg        rst_seen_q = 1'b0;
   reg        ack_q;
   wire       acc;
   wire       wr_hit;
   wire       cmd_valid;
   wire       store_go;
   wire       load_go;
   wire       busy;
   wire       buf_clear;
   wire       buf_wr;
   wire       any_loaded;
   wire [15:0] buf_rd;

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function [7:0] sel_byte;
      input [15:0] w;
      input        hi;
      begin
         sel_byte = hi ? w[15:8] : w[7:0];
      end
   endfunction

   function legal_cmd;
      input [4:0] c;
      begin
         legal_cmd = (c == `FSPS_CMD_ERASE) || (c == `FSPS_CMD_LOAD) ||
                     (c == `FSPS_CMD_WRITE) || (c == `FSPS_CMD_LOCKRD) ||
                     (c == `FSPS_CMD_RSE);
      end
   endfunction

   // --------------------------------------------------------------
   // EEPROM busy synchroniser
   // --------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ee_s1_q <= 1'b0;
         ee_s2_q <= 1'b0;
         ee_d_q  <= 1'b0;
      end else begin
         ee_s1_q <= ee_busy_i;
         ee_s2_q <= ee_s1_q;
         ee_d_q  <= ee_s2_q;
      end
   end

   // --------------------------------------------------------------
   // Bus handshake: one wait cycle, then acknowledge
   // --------------------------------------------------------------
   assign acc             = avs_read | avs_write;
   assign avs_waitrequest = acc & ~ack_q;
   assign wr_hit          = avs_write & ack_q;
   assign busy            = (st_q != ST_IDLE);

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc & ~ack_q;
      end
   end

   assign cmd_valid = wr_hit && (avs_address == `FSPS_ADDR_CTRL) &&
                      legal_cmd(avs_writedata[4:0]) && !ee_s2_q && !busy;
   assign store_go  = wr_hit && (avs_address == `FSPS_ADDR_STORE) &&
                      ctrl_q[`FSPS_BIT_ENABLE] && (win_q != 3'h0) && !busy &&
                      !ee_s2_q;
   assign load_go   = avs_read && ack_q && (avs_address == `FSPS_ADDR_LOAD);

   // --------------------------------------------------------------
   // Pointer and data registers
   // --------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr_q  <= 16'h0000;
         data_q <= 16'h0000;
      end else if (wr_hit && !busy) begin
         if (avs_address == `FSPS_ADDR_PTR) begin
            ptr_q <= avs_writedata[15:0];
         end
         if (avs_address == `FSPS_ADDR_DATA) begin
            data_q <= avs_writedata[15:0];
         end
      end
   end

   // --------------------------------------------------------------
   // Control register, window and operation sequencer
   // --------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= `FSPS_RST_CTRL;
         win_q  <= 3'h0;
      end else if (busy) begin
         if (st_q != ST_IDLE && cnt_q == {CW{1'b0}}) begin
            ctrl_q <= `FSPS_RST_CTRL;
         end
      end else if (cmd_valid) begin
         ctrl_q <= {3'h0, avs_writedata[4:0]};
         win_q  <= `FSPS_STORE_WIN;
      end else if (store_go) begin
         // long ops keep bits until done
         if (ctrl_q[4:0] != `FSPS_CMD_ERASE && ctrl_q[4:0] != `FSPS_CMD_WRITE) begin
            ctrl_q <= `FSPS_RST_CTRL;
         end
         win_q <= 3'h0;
      end else if (ctrl_q[`FSPS_BIT_LOCKRD] && load_go &&
                   (`FSPS_STORE_WIN - win_q) < `FSPS_LOAD_WIN) begin
         ctrl_q <= `FSPS_RST_CTRL;
         win_q  <= 3'h0;
      end else if (win_q != 3'h0) begin
         win_q <= win_q - 3'h1;
         if (win_q == 3'h1) begin
            ctrl_q <= `FSPS_RST_CTRL;
         end
      end
   end

   // op state kept through reset so the write completes
   always @(posedge ref_clk_i) begin
      if (!rst_seen_q) begin
         st_q       <= ST_IDLE;
         cnt_q      <= {CW{1'b0}};
         fl_erase_o <= 1'b0;
         fl_prog_o  <= 1'b0;
         page_q     <= {PAGE_BITS{1'b0}};
      end else if (st_q == ST_IDLE) begin
         if (store_go && ctrl_q[4:0] == `FSPS_CMD_ERASE) begin
            st_q       <= ST_ERASE;
            page_q     <= ptr_q[WORD_BITS+PAGE_BITS:WORD_BITS+1];
            cnt_q      <= PROG_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            fl_erase_o <= 1'b1;
         end else if (store_go && ctrl_q[4:0] == `FSPS_CMD_WRITE) begin
            st_q      <= ST_WRITE;
            page_q    <= ptr_q[WORD_BITS+PAGE_BITS:WORD_BITS+1];
            cnt_q     <= PROG_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            fl_prog_o <= 1'b1;
         end
      end else if (cnt_q == {CW{1'b0}}) begin
         st_q       <= ST_IDLE;
         fl_erase_o <= 1'b0;
         fl_prog_o  <= 1'b0;
      end else begin
         cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // First clock after power-up initialises the op state once
   always @(posedge ref_clk_i) begin
      rst_seen_q <= 1'b1;
   end

   always @* begin
      fl_page_o = page_q;
   end

   // halt CPU for erase and write
   assign cpu_halt_o = busy;

   // --------------------------------------------------------------
   // Page buffer control
   // --------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending_q <= 1'b0;
      end else begin
         pending_q <= any_loaded;
      end
   end

   // load stores data word at word field
   assign buf_wr = store_go && (ctrl_q[4:0] == `FSPS_CMD_LOAD);
   // write done, section enable, EEPROM start while loading
   assign buf_clear = (st_q == ST_WRITE && cnt_q == {CW{1'b0}}) ||
                      (store_go && ctrl_q[4:0] == `FSPS_CMD_RSE) ||
                      (ee_s2_q && !ee_d_q && pending_q);

   fsps_page_buf #(
      .WORDS (1 << WORD_BITS),
      .AW    (WORD_BITS)
   ) u_buf (
      .ref_clk_i    (ref_clk_i),
      .rst_n_i      (rst_n_i),
      .clear_i      (buf_clear),
      .wr_i         (buf_wr),
      .wr_idx_i     (ptr_q[WORD_BITS:1]),
      .wr_data_i    (data_q),
      .rd_idx_i     (fl_word_o),
      .rd_data_o    (buf_rd),
      .any_loaded_o (any_loaded)
   );

   // buffer streamed by word index during write
   assign fl_word_o  = cnt_q[WORD_BITS-1:0];
   assign fl_wdata_o = buf_rd;
   assign fl_raddr_o = ptr_q[PAGE_BITS+WORD_BITS:1];

   // --------------------------------------------------------------
   // Read data mux
   // --------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         case (avs_address)
            `FSPS_ADDR_CTRL:   avs_readdata <= {24'h000000, ctrl_q};
            `FSPS_ADDR_PTR:    avs_readdata <= {16'h0000, ptr_q};
            `FSPS_ADDR_DATA:   avs_readdata <= {16'h0000, data_q};
            `FSPS_ADDR_STATUS: avs_readdata <= {30'h00000000, ee_s2_q, busy};
            `FSPS_ADDR_LOAD: begin
               if (ctrl_q[`FSPS_BIT_LOCKRD] && !ee_s2_q &&
                   (`FSPS_STORE_WIN - win_q) < `FSPS_LOAD_WIN) begin
                  case (ptr_q)
                     `FSPS_SEL_LOCK:     avs_readdata <= {24'h000000, lock_bits_i};
                     `FSPS_SEL_FUSE_LO:  avs_readdata <= {24'h000000, fuse_lo_i};
                     `FSPS_SEL_FUSE_HI:  avs_readdata <= {24'h000000, fuse_hi_i};
                     `FSPS_SEL_FUSE_EXT: avs_readdata <= {24'h000000, fuse_ext_i};
                     default:            avs_readdata <= 32'h000000FF;
                  endcase
               end else begin
                  avs_readdata <= {24'h000000, sel_byte(fl_rdata_i, ptr_q[0])};
               end
            end
            default: avs_readdata <= 32'h00000000;
         endcase
      end
   end
endmodule

/* fsps_seq_monitor.sv */
module fsps_seq_monitor #(
   parameter PROG_CYC  = 20,
   parameter PAGE_BITS = 7
) (
   // Clock and reset
   input wire                 ref_clk_i,
   input wire                 rst_n_i,
   // Bus and status
   input wire                 avs_read,
   input wire                 avs_write,
   input wire                 avs_waitrequest,
   input wire                 ee_busy_i,
   // Array side
   input wire                 fl_erase_o,
   input wire                 fl_prog_o,
   input wire [PAGE_BITS-1:0] fl_page_o,
   input wire                 cpu_halt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Op length counter, not reset: ops run through reset
   reg [31:0] op_cnt_q = 32'h0;
   always @(posedge ref_clk_i) begin
      op_cnt_q <= (fl_erase_o | fl_prog_o) ? op_cnt_q + 32'h1 : 32'h0;
   end
   sequence s_req_new;
      (avs_read || avs_write) && !$past(avs_read || avs_write);
   endsequence
   sequence s_req_held;
      (avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write);
   endsequence
   a_halt_erase: assert property (fl_erase_o |-> cpu_halt_o)
      else $error("halt low during erase");
   a_halt_prog: assert property (fl_prog_o |-> cpu_halt_o)
      else $error("halt low during page write");
   a_wait_first: assert property (s_req_new |-> avs_waitrequest)
      else $error("no wait state on new access");
   a_wait_once: assert property (s_req_held |-> !avs_waitrequest)
      else $error("second wait state");
   a_erase_len: assert property ($fell(fl_erase_o) |-> op_cnt_q == PROG_CYC)
      else $error("erase length wrong");
   a_prog_len: assert property ($fell(fl_prog_o) |-> op_cnt_q == PROG_CYC)
      else $error("write length wrong");
   a_op_excl: assert property (!(fl_erase_o && fl_prog_o))
      else $error("erase and write together");
   a_ee_block: assert property (ee_busy_i [*4] |-> !$rose(fl_erase_o) && !$rose(fl_prog_o))
      else $error("op started while eeprom busy");
   a_page_stable: assert property (fl_erase_o && $past(fl_erase_o) |-> $stable(fl_page_o))
      else $error("page moved during erase");
endmodule
bind fsps_seq fsps_seq_monitor #(.PROG_CYC(PROG_CYC), .PAGE_BITS(PAGE_BITS)) fsps_seq_monitor_i (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .ee_busy_i(ee_busy_i), .fl_erase_o(fl_erase_o),
   .fl_prog_o(fl_prog_o), .fl_page_o(fl_page_o), .cpu_halt_o(cpu_halt_o));

/* fsps_flash_model.sv */
// Program array: erase sets ones, program only clears bits
module fsps_flash_model (
   input  wire        ref_clk_i,
   input  wire        erase_i,
   input  wire        prog_i,
   input  wire [6:0]  page_i,
   input  wire [4:0]  word_i,
   input  wire [15:0] wdata_i,
   input  wire [11:0] raddr_i,
   output wire [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [15:0] mem [0:4095];
   integer    k;
   initial begin
      for (k = 0; k < 4096; k = k + 1) mem[k] = 16'h0000;
   end
   // Array update per cycle of the op
   always @(posedge ref_clk_i) begin
      if (erase_i) begin
         for (k = 0; k < 32; k = k + 1) mem[{page_i, k[4:0]}] <= 16'hFFFF;
      end else if (prog_i) begin
         mem[{page_i, word_i}] <= mem[{page_i, word_i}] & wdata_i;
      end
   end
   assign rdata_o = mem[raddr_i];
endmodule

/* fsps_seq_tb_top.sv */
`include "fsps_regs.vh"
module fsps_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   reg ref_clk_i = 1'b0, rst_n_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ee_busy_i = 1'b0;
   reg  [3:0]  avs_address = 4'h0;
   reg  [31:0] avs_writedata = 32'h0, q;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, fl_erase_o, fl_prog_o, cpu_halt_o;
   wire [6:0]  fl_page_o;
   wire [4:0]  fl_word_o;
   wire [15:0] fl_wdata_o, fl_rdata_i;
   wire [11:0] fl_raddr_o;
   integer     bad_count = 0, tests_run = 0, i;
   reg         got;
   reg  [7:0]  fz [0:3];
   always #5 ref_clk_i = ~ref_clk_i;
   fsps_seq #(.PROG_CYC(20)) fsps_seq_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ee_busy_i(ee_busy_i), .lock_bits_i(fz[1]),
      .fuse_lo_i(fz[0]), .fuse_hi_i(fz[3]), .fuse_ext_i(fz[2]), .fl_erase_o(fl_erase_o),
      .fl_prog_o(fl_prog_o), .fl_page_o(fl_page_o), .fl_word_o(fl_word_o),
      .fl_wdata_o(fl_wdata_o), .fl_raddr_o(fl_raddr_o), .fl_rdata_i(fl_rdata_i),
      .cpu_halt_o(cpu_halt_o));
   fsps_flash_model fsps_flash_model_i (.ref_clk_i(ref_clk_i), .erase_i(fl_erase_o),
      .prog_i(fl_prog_o), .page_i(fl_page_o), .word_i(fl_word_o), .wdata_i(fl_wdata_o),
      .raddr_i(fl_raddr_o), .rdata_o(fl_rdata_i));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task check(input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Hold until waitrequest sampled low, then one idle edge
   task bus(input wr, input [3:0] a, input [31:0] d);
      integer n;
      avs_address <= a; avs_write <= wr; avs_read <= !wr; avs_writedata <= d;
      n = 0;
      do begin @(posedge ref_clk_i); n = n + 1; end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0; avs_read <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   // Command then store; eeprom busy is not checked here
   task cmd(input [15:0] ptr, input [4:0] c);
      bus(1, `FSPS_ADDR_PTR, {16'h0, ptr});
      bus(1, `FSPS_ADDR_CTRL, {27'h0, c});
      bus(1, `FSPS_ADDR_STORE, 32'h0);
   endtask
   // Bounded wait for a halt window; got tells whether one came
   task wait_op;
      integer n;
      got = 1'b0;
      for (n = 0; n < 10 && !got; n = n + 1) begin @(posedge ref_clk_i); got = (cpu_halt_o === 1'b1); end
      for (n = 0; n < 40 && cpu_halt_o === 1'b1; n = n + 1) @(posedge ref_clk_i);
   endtask
   task end_sim;
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count = bad_count + 1;
      end_sim;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      fz[0] = 8'h5A; fz[1] = 8'hC3; fz[2] = 8'hF7; fz[3] = 8'h1E;
      repeat (4) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      check(cpu_halt_o, 1'b0);
      // Lock and fuse reads, raw bits passed as read
      for (i = 0; i < 4; i = i + 1) begin
         bus(1, `FSPS_ADDR_PTR, i);
         bus(1, `FSPS_ADDR_CTRL, {27'h0, `FSPS_CMD_LOCKRD});
         bus(0, `FSPS_ADDR_LOAD, 32'h0);
         check(q[7:0], fz[i]);
         bus(0, `FSPS_ADDR_CTRL, 32'h0);
         check(q[4:0], 5'h00);
      end
      // Loads out of order, words 3 then 1 of page 5
      // one load per word, same page, zero low bits
      bus(1, `FSPS_ADDR_DATA, 32'h0000_1234);
      cmd(16'h0146, `FSPS_CMD_LOAD);
      bus(1, `FSPS_ADDR_DATA, 32'h0000_ABCD);
      cmd(16'h0142, `FSPS_CMD_LOAD);
      bus(1, `FSPS_ADDR_DATA, 32'h0000_0000);
      cmd(16'h017F, `FSPS_CMD_ERASE); // junk word bits
      wait_op;
      check(got, 1'b1);
      check(fsps_flash_model_i.mem[12'h0A2], 16'hFFFF);
      check(fsps_flash_model_i.mem[12'h0E2], 16'h0000);
      cmd(16'h0140, `FSPS_CMD_WRITE);
      wait_op;
      check(got, 1'b1);
      check(fsps_flash_model_i.mem[12'h0A3], 16'h1234);
      check(fsps_flash_model_i.mem[12'h0A1], 16'hABCD);
      // Plain bytewise reads of word 3, disarmed
      for (i = 0; i < 2; i = i + 1) begin
         bus(1, `FSPS_ADDR_PTR, 32'h0146 + i);
         bus(0, `FSPS_ADDR_LOAD, 32'h0);
         check(q[7:0], i ? 8'h12 : 8'h34);
      end
      // Lock read armed but load too late: plain read
      bus(1, `FSPS_ADDR_PTR, 32'h0147);
      bus(1, `FSPS_ADDR_CTRL, {27'h0, `FSPS_CMD_LOCKRD});
      repeat (6) @(posedge ref_clk_i);
      bus(0, `FSPS_ADDR_CTRL, 32'h0);
      check(q[4:0], 5'h00);
      bus(0, `FSPS_ADDR_LOAD, 32'h0);
      check(q[7:0], 8'h12);
      // Store arriving too late does nothing
      bus(1, `FSPS_ADDR_CTRL, {27'h0, `FSPS_CMD_ERASE});
      repeat (8) @(posedge ref_clk_i);
      bus(1, `FSPS_ADDR_STORE, 32'h0);
      wait_op;
      check(got, 1'b0);
      // EEPROM busy shows in status and refuses commands
      ee_busy_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      bus(0, `FSPS_ADDR_STATUS, 32'h0);
      check(q[1], 1'b1);
      cmd(16'h0140, `FSPS_CMD_ERASE);
      wait_op;
      check(got, 1'b0);
      check(fsps_flash_model_i.mem[12'h0A3], 16'h1234);
      ee_busy_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      // EEPROM write during loading loses page 6 word 3
      bus(1, `FSPS_ADDR_DATA, 32'h0000_5555);
      cmd(16'h0186, `FSPS_CMD_LOAD);
      ee_busy_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      ee_busy_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      cmd(16'h0180, `FSPS_CMD_ERASE);
      wait_op;
      cmd(16'h0180, `FSPS_CMD_WRITE);
      wait_op;
      check(fsps_flash_model_i.mem[12'h0C3], 16'hFFFF);
      // Section enable empties the buffer: page 7 word 1 stays blank
      bus(1, `FSPS_ADDR_DATA, 32'h0000_0F0F);
      cmd(16'h01C2, `FSPS_CMD_LOAD);
      cmd(16'h0000, `FSPS_CMD_RSE);
      cmd(16'h01C0, `FSPS_CMD_ERASE);
      wait_op;
      cmd(16'h01C0, `FSPS_CMD_WRITE);
      wait_op;
      check(fsps_flash_model_i.mem[12'h0E1], 16'hFFFF);
      // Reset in mid write must not stop it
      cmd(16'h0180, `FSPS_CMD_WRITE);
      repeat (6) @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      check(fl_prog_o, 1'b1);
      rst_n_i <= 1'b1;
      for (i = 0; i < 40 && fl_prog_o === 1'b1; i = i + 1) @(posedge ref_clk_i);
      check(fl_prog_o, 1'b0);
      end_sim;
   end
endmodule
